// *** hdl/spi_port_pkg.sv ***
// Package: constants for the serial register access port
package spi_port_pkg;
    localparam int          BYTE_W      = 8;
    localparam int          ADDR_W      = 5;
    localparam int          NUM_REGS    = 32;
    // Instruction byte fields
    localparam int          INSTR_DIR_BIT  = 7;
    localparam int          INSTR_CNT_MSB  = 6;
    localparam int          INSTR_CNT_LSB  = 5;
    localparam int          INSTR_ADDR_MSB = 4;
    localparam logic        DIR_WRITE      = 1'b0;
    localparam logic        DIR_READ       = 1'b1;
    // Common control register and its bits
    localparam logic [4:0]  COMMON_ADDR    = 5'h00;
    localparam int          THREE_WIRE_BIT = 7;
    localparam int          SOFT_RST_BIT   = 6;
    localparam logic [2:0]  LAST_BIT       = 3'h7;
    // Register defaults after reset
    localparam logic [7:0]  REG_DEFAULT [NUM_REGS] = '{
        8'h80, 8'h87, 8'h10, 8'h66, 8'h66, 8'h66, 8'h26, 8'h00,
        8'h00, 8'h00, 8'h40, 8'hc0, 8'h00, 8'h40, 8'hc0, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
    typedef enum logic [1:0] {ST_INSTR, ST_DATA, ST_DONE} link_state_t;
endpackage : spi_port_pkg

// *** hdl/reg_link_if.sv ***
// Interface: carrier between serial link logic and register core
`timescale 1ns/1ns
interface reg_link_if;
    import spi_port_pkg::*;
    logic              wr_tog;
    logic [ADDR_W-1:0] wr_addr;
    logic [BYTE_W-1:0] wr_data;
    logic [ADDR_W-1:0] rd_addr;
    logic [BYTE_W-1:0] rd_data;
    logic              three_wire;
    modport link (output wr_tog, output wr_addr, output wr_data, output rd_addr,
                  input rd_data, input three_wire);
    modport core (input wr_tog, input wr_addr, input wr_data, input rd_addr,
                  output rd_data, output three_wire);
endinterface : reg_link_if

// *** hdl/spi_link_shifter.sv ***
// Serial link side: shifts instruction and data on the serial clock
`timescale 1ns/1ns
module spi_link_shifter
    import spi_port_pkg::*;
(
    input  wire logic  sclk_in,
    input  wire logic  chip_select_low_in,
    input  wire logic  sdio_in,
    output logic       sdio_out,
    output logic       sdio_oe_out,
    output logic       serial_data_out_out,
    output logic       serial_data_out_oe_out,
    reg_link_if.link   lnk
);
    link_state_t       state_r, state_nxt;
    logic [2:0]        bit_cnt_r, bit_cnt_nxt;
    logic [6:0]        shift_r, shift_nxt;
    logic              is_read_r, is_read_nxt;
    logic [1:0]        left_r, left_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    // Write handoff; held stable between toggles, never reset by select
    logic              wr_tog_r = 1'b0;
    logic              wr_tog_nxt;
    logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
    logic [BYTE_W-1:0] wr_data_r, wr_data_nxt;
    logic              tw_s1_r, tw_s2_r;
    logic              tx_bit_r;
    logic              oe3_r, oe4_r;
    logic              read_phase;
    logic [BYTE_W-1:0] byte_in;

    ////////////////////////////////////////////////////////////////////////////
    // Frame decoder, sampled on rising serial clock, MSB first
    always_comb begin
        byte_in     = {shift_r, sdio_in};
        state_nxt   = state_r;
        bit_cnt_nxt = bit_cnt_r + 3'h1;
        shift_nxt   = byte_in[6:0];
        is_read_nxt = is_read_r;
        left_nxt    = left_r;
        addr_nxt    = addr_r;
        wr_tog_nxt  = wr_tog_r;
        wr_addr_nxt = wr_addr_r;
        wr_data_nxt = wr_data_r;
        if (bit_cnt_r == LAST_BIT) begin
            unique case (state_r)
                ST_INSTR: begin
                    is_read_nxt = (byte_in[INSTR_DIR_BIT] == DIR_READ);
                    left_nxt    = byte_in[INSTR_CNT_MSB:INSTR_CNT_LSB];
                    addr_nxt    = byte_in[INSTR_ADDR_MSB:0];
                    state_nxt   = ST_DATA;
                end
                ST_DATA: begin
                    if (!is_read_r) begin
                        wr_addr_nxt = addr_r;
                        wr_data_nxt = byte_in;
                        wr_tog_nxt  = ~wr_tog_r;
                    end
                    addr_nxt = addr_r - 5'h01;
                    left_nxt = left_r - 2'h1;
                    if (left_r == 2'h0) begin
                        state_nxt = ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_nxt = ST_DONE;           // Extra clocks ignored until deselect
                end
            endcase
        end
    end

    // Deselect aborts the frame at once
    always_ff @(posedge sclk_in or posedge chip_select_low_in) begin
        if (chip_select_low_in) begin
            state_r   <= ST_INSTR;
            bit_cnt_r <= 3'h0;
            shift_r   <= 7'h00;
            is_read_r <= 1'b0;
            left_r    <= 2'h0;
            addr_r    <= 5'h00;
        end else begin
            state_r   <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r   <= shift_nxt;
            is_read_r <= is_read_nxt;
            left_r    <= left_nxt;
            addr_r    <= addr_nxt;
        end
    end

    // Write handoff registers and mode-bit synchroniser
    always_ff @(posedge sclk_in) begin
        wr_tog_r  <= wr_tog_nxt;
        wr_addr_r <= wr_addr_nxt;
        wr_data_r <= wr_data_nxt;
        tw_s1_r   <= lnk.three_wire;
        tw_s2_r   <= tw_s1_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read drive holds past the counted bytes; only deselect may drop it
    assign read_phase = (state_r != ST_INSTR) && is_read_r;

    // Read data and enables launched on falling edge, half a clock ahead of sampling
    always_ff @(negedge sclk_in or posedge chip_select_low_in) begin
        if (chip_select_low_in) begin
            tx_bit_r <= 1'b0;
            oe3_r    <= 1'b0;
            oe4_r    <= 1'b0;
        end else begin
            tx_bit_r <= lnk.rd_data[3'h7 - bit_cnt_r];
            oe3_r    <= read_phase & tw_s2_r;
            oe4_r    <= read_phase & ~tw_s2_r;
        end
    end

    // Pin steering by wiring mode, every pin straight from a flop
    assign sdio_out               = tx_bit_r;
    assign sdio_oe_out            = oe3_r;
    assign serial_data_out_out    = tx_bit_r;
    assign serial_data_out_oe_out = oe4_r;
    assign lnk.wr_tog             = wr_tog_r;
    assign lnk.wr_addr            = wr_addr_r;
    assign lnk.wr_data            = wr_data_r;
    assign lnk.rd_addr            = addr_r;
endmodule : spi_link_shifter

// *** hdl/serial_register_access_port.sv ***
// Top: serial register access port with register file on the core clock
`timescale 1ns/1ns
module serial_register_access_port
    import spi_port_pkg::*;
(
    input  wire logic                       clk_in,
    input  wire logic                       rst_in,
    input  wire logic                       sclk_in,
    input  wire logic                       chip_select_low_in,
    input  wire logic                       sdio_in,
    output logic                            sdio_out,
    output logic                            sdio_oe_out,
    output logic                            serial_data_out_out,
    output logic                            serial_data_out_oe_out,
    output logic                            three_wire_select_out,
    output logic [NUM_REGS*BYTE_W-1:0]      regs_out
);
    reg_link_if lnk ();

    logic [BYTE_W-1:0] regs_r   [NUM_REGS];
    logic [BYTE_W-1:0] regs_nxt [NUM_REGS];
    logic              tog_s1_r, tog_s2_r;
    logic              ack_r, ack_nxt;
    logic              wr_evt;

    ////////////////////////////////////////////////////////////////////////////
    // Link-side shifter on the serial clock
    spi_link_shifter u_link (
        .sclk_in                (sclk_in),
        .chip_select_low_in     (chip_select_low_in),
        .sdio_in                (sdio_in),
        .sdio_out               (sdio_out),
        .sdio_oe_out            (sdio_oe_out),
        .serial_data_out_out    (serial_data_out_out),
        .serial_data_out_oe_out (serial_data_out_oe_out),
        .lnk                    (lnk.link)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Write toggle crossing: second stage only is compared
    always_ff @(posedge clk_in) begin
        tog_s1_r <= lnk.wr_tog;
        tog_s2_r <= tog_s1_r;
    end

    assign wr_evt = (tog_s2_r != ack_r);

    // Ack follows toggle; on reset it resyncs so no stale write fires
    always_comb begin
        ack_nxt = tog_s2_r;
    end

    always_ff @(posedge clk_in) begin
        ack_r <= ack_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file next state
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            regs_nxt[i] = regs_r[i];
        end
        if (rst_in) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_nxt[i] = REG_DEFAULT[i];
            end
        end else if (wr_evt) begin
            if (lnk.wr_addr == COMMON_ADDR && lnk.wr_data[SOFT_RST_BIT]) begin
                // Soft reset; common register takes the written value, reset bit self-clears
                for (int i = 1; i < NUM_REGS; i++) begin
                    regs_nxt[i] = REG_DEFAULT[i];
                end
                regs_nxt[0] = lnk.wr_data;
                regs_nxt[0][SOFT_RST_BIT] = 1'b0;
            end else begin
                regs_nxt[lnk.wr_addr] = lnk.wr_data;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        for (int i = 0; i < NUM_REGS; i++) begin
            regs_r[i] <= regs_nxt[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flat register view and wiring mode, straight from flip-flops
    generate
        for (genvar g = 0; g < NUM_REGS; g++) begin : g_flat
            assign regs_out[g*BYTE_W +: BYTE_W] = regs_r[g];
        end
    endgenerate

    assign three_wire_select_out = regs_r[0][THREE_WIRE_BIT];
    assign lnk.three_wire        = regs_r[0][THREE_WIRE_BIT];

    // Read path: quasi-static data, changes only after a completed write or an rst_in reset
    assign lnk.rd_data = regs_r[lnk.rd_addr];
endmodule : serial_register_access_port

// *** test/sap_props.sv ***
// Checker: port-level properties of the serial register port
`timescale 1ns/1ns
module sap_props
    import spi_port_pkg::*;
(
    input  wire logic                       clk_in,
    input  wire logic                       rst_in,
    input  wire logic                       chip_select_low_in,
    input  wire logic                       sdio_oe_out,
    input  wire logic                       serial_data_out_oe_out,
    input  wire logic                       three_wire_select_out,
    input  wire logic [NUM_REGS*BYTE_W-1:0] regs_out
);
    logic [NUM_REGS*BYTE_W-1:0] prev_r;
    logic [NUM_REGS*BYTE_W-1:0] dflt_flat;
    logic [5:0]                 chg_cnt;

    // Previous register view, to spot several registers moving at once
    always_ff @(posedge clk_in) begin
        prev_r <= regs_out;
    end

    // Flat default image to compare against
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_dflt
        assign dflt_flat[g*BYTE_W +: BYTE_W] = REG_DEFAULT[g];
    end

    // Only a soft reset or an rst_in reset moves more than one register in one cycle
    always_comb begin
        chg_cnt = 6'h00;
        for (int i = 1; i < NUM_REGS; i++) begin
            if (regs_out[i*BYTE_W +: BYTE_W] != prev_r[i*BYTE_W +: BYTE_W]) begin
                chg_cnt = chg_cnt + 6'h01;
            end
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_pins_exclusive: assert property (!(sdio_oe_out && serial_data_out_oe_out))
        else $error("both data outputs driven");
    a_idle_released: assert property (chip_select_low_in |-> !sdio_oe_out && !serial_data_out_oe_out)
        else $error("output driven while deselected");
    a_mode_follows: assert property (three_wire_select_out == regs_out[THREE_WIRE_BIT])
        else $error("mode pin differs from register");
    a_three_wire_pin: assert property (sdio_oe_out |-> regs_out[THREE_WIRE_BIT])
        else $error("data pin driven in four-wire mode");
    a_four_wire_pin: assert property (serial_data_out_oe_out |-> !regs_out[THREE_WIRE_BIT])
        else $error("output pin driven in three-wire mode");
    a_read_holds: assert property ($fell(sdio_oe_out) || $fell(serial_data_out_oe_out) |-> chip_select_low_in)
        else $error("read drive dropped inside frame");
    a_regs_quiet: assert property (chip_select_low_in [*8] |=> $stable(regs_out))
        else $error("register changed outside a frame");
    a_soft_restores: assert property (chg_cnt > 6'h01 |-> regs_out[NUM_REGS*BYTE_W-1:BYTE_W] == dflt_flat[NUM_REGS*BYTE_W-1:BYTE_W])
        else $error("soft reset left a register off default");
    // Main scenarios reached
    cover property (sdio_oe_out);
    cover property (serial_data_out_oe_out);
    cover property ($fell(three_wire_select_out));
    cover property (chg_cnt > 6'h01);
endmodule : sap_props

bind serial_register_access_port sap_props chk_u (.clk_in, .rst_in, .chip_select_low_in,
    .sdio_oe_out, .serial_data_out_oe_out, .three_wire_select_out, .regs_out);

// *** test/spi_host_model.sv ***
// Host model: bus master that frames and clocks serial transfers
`timescale 1ns/1ns
module spi_host_model (
    output logic      sclk_out,
    output logic      csn_out,
    output logic      mosi_out,
    output logic      mosi_oe_out,
    input  wire logic miso_in
);
    // Idle bus: clock stands low, deselected; select rises a step late so
    // the link logic surely sees an edge and starts from its reset state
    initial begin
        sclk_out = 1'b0;
        mosi_out = 1'b0;
        mosi_oe_out = 1'b0;
        #1 csn_out = 1'b1;
    end
    // One frame; a bit count short of the byte count abandons it
    task automatic frame(input logic [7:0] ins, input logic [31:0] wd, input int nbits,
                         output logic [31:0] rd);
        logic [39:0] sh;
        sh = {ins, wd};
        rd = '0;
        csn_out = 1'b0;
        #20;
        for (int i = 0; i < nbits; i++) begin
            mosi_out = sh[39-i];
            mosi_oe_out = !(ins[7] && i >= 8); // Let go for read data
            #15 sclk_out = 1'b1;
            if (i >= 8) rd = {rd[30:0], miso_in};
            #15 sclk_out = 1'b0;
        end
        #20 csn_out = 1'b1;
        mosi_oe_out = 1'b0;
        #45;
    endtask : frame
endmodule : spi_host_model

// *** test/serial_register_access_port_tb.sv ***
// Testbench: random register traffic through the port against a queue-free model
`timescale 1ns/1ns
module serial_register_access_port_tb;
    import spi_port_pkg::*;
    logic                       clk_in, rst_in, sclk, csn, mosi, mosi_oe;
    logic                       sdio_out, sdio_oe, serial_data_out, sdo_oe, mode;
    logic [NUM_REGS*BYTE_W-1:0] regs;
    logic [31:0]                rd;
    logic [7:0]                 model [NUM_REGS];
    int                         error_cnt, checked, cyc, seed, a;
    // Released lines show the inverse of their last bit, not a kind guess
    wire logic sdio_line = sdio_oe ? sdio_out : (mosi_oe ? mosi : ~mosi);
    wire logic sdo_line = sdo_oe ? serial_data_out : ~serial_data_out;

    serial_register_access_port dut_u (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk),
        .chip_select_low_in(csn), .sdio_in(sdio_line), .sdio_out(sdio_out),
        .sdio_oe_out(sdio_oe), .serial_data_out_out(serial_data_out), .serial_data_out_oe_out(sdo_oe),
        .three_wire_select_out(mode), .regs_out(regs));
    spi_host_model host_u (.sclk_out(sclk), .csn_out(csn), .mosi_out(mosi),
        .mosi_oe_out(mosi_oe), .miso_in(model[0][7] ? sdio_line : sdo_line));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    // One frame, model kept in step, then every register compared
    task automatic xfer(input logic dir, input int cnt, input int adr, input logic [31:0] wd,
                        input int nbits);
        host_u.frame({dir, cnt[1:0], adr[4:0]}, wd, nbits, rd);
        for (int k = 0; k <= cnt && k < (nbits - 8) / 8; k++) begin
            if (dir) chk("read", model[(adr-k)&31], (rd >> (8*((nbits-16)/8-k))) & 32'hff);
            else model[(adr-k)&31] = wd[31-8*k -: 8];
        end
        if (!dir && model[0][SOFT_RST_BIT]) begin
            for (int r = 1; r < NUM_REGS; r++) model[r] = REG_DEFAULT[r];
            model[0][SOFT_RST_BIT] = 1'b0;
        end
        repeat (8) @(negedge clk_in);
        for (int r = 0; r < NUM_REGS; r++) chk("reg", model[r], regs[8*r +: 8]);
        chk("mode", model[0][7], mode);
    endtask : xfer
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // Hang guard, far above the roughly 1200 cycles the run needs
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    // Both wirings, all byte counts, soft reset, early deselect
    initial begin
        seed = 19098;
        rst_in = 1'b1;
        for (int r = 0; r < NUM_REGS; r++) model[r] = REG_DEFAULT[r];
        repeat (8) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (2) @(negedge clk_in);
        for (int w = 0; w < 2; w++) begin
            for (int i = 0; i < 8; i++) begin
                a = 4 + {$random(seed)} % 28;
                xfer(1'b0, i % 4, a, $random(seed), 16 + 8 * (i % 4));
                xfer(1'b1, i % 4, a, $random(seed), 16 + 8 * (i % 4));
            end
            xfer(1'b0, 0, 0, {(w ? 8'h40 : 8'h00), 24'h0}, 16);
        end
        xfer(1'b0, 2, 12, $random(seed), 19);
        xfer(1'b1, 3, 13, 32'h0, 40);
        xfer(1'b0, 0, 0, 32'h80000000, 16);
        xfer(1'b1, 3, 3, 32'h0, 40);
        wrap_up();
    end
endmodule : serial_register_access_port_tb
